// *** verilog/dtu_pkg.sv ***
/*
 * Package for the decimal unit trap and interrupt controller: register map,
 * field layout of the restart status word, opcode and function codes, states.
 * Assumes a single core clock and an Avalon-MM register port of 32-bit words.
 */
package dtu_pkg;

    // Register byte offsets
    localparam logic [3:0] DTU_OFS_CONTROL = 4'h0;
    localparam logic [3:0] DTU_OFS_RESTART = 4'h4;
    localparam logic [3:0] DTU_OFS_STATUS = 4'h8;
    localparam logic [3:0] DTU_OFS_RECOVERY = 4'hC;

    // Control register fields
    localparam int DTU_CTL_ENABLE_BIT = 0;
    localparam int DTU_CTL_FITTED_BIT = 1;
    localparam logic [1:0] DTU_CTL_RESET = 2'h3;

    // Restart status word layout
    localparam int DTU_RS_WIDTH = 15;
    localparam int DTU_RS_COUNT_W = 12;
    localparam int DTU_RS_PASS2_BIT = 12;
    localparam int DTU_RS_CARRY_BIT = 13;
    localparam int DTU_RS_FAULT_BIT = 14;
    localparam logic [14:0] DTU_RS_RESET = 15'h0000;

    // Decimal group opcodes and function codes
    localparam logic [5:0] DTU_OP_FIRST = 6'h34;
    localparam logic [5:0] DTU_OP_LAST = 6'h38;
    localparam logic [5:0] DTU_OP_66 = 6'h36;
    localparam logic [5:0] DTU_OP_67 = 6'h37;
    localparam logic [5:0] DTU_OP_70 = 6'h38;
    localparam logic [2:0] DTU_FN_ADD = 3'h0;
    localparam logic [2:0] DTU_FN_SUB = 3'h1;
    localparam logic [2:0] DTU_FN_TEST = 3'h4;
    localparam logic [2:0] DTU_FN_LOADREC = 3'h0;
    localparam logic [2:0] DTU_FN_STOREREC = 3'h1;

    // Unit states
    typedef enum logic [1:0] {
        DTU_IDLE = 2'b00,
        DTU_RUN = 2'b01,
        DTU_DONE = 2'b10
    } dtu_state_t;

    localparam logic [31:0] DTU_UNMAPPED_DATA = 32'h00000000;

endpackage

// *** verilog/dtu_char_step.sv ***
/*
 * One character step of the decimal unit: counts processed characters,
 * keeps the carry, pass and digit fault flags of the running instruction.
 * Assumes the step strobe comes from main control once per character.
 */
module dtu_char_step
    import dtu_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic clkEn,
    // Control
    input wire logic startLoad,
    input wire logic [14:0] startValue,
    input wire logic charStep,
    input wire logic carryIn,
    input wire logic secondPass,
    input wire logic digitFault,
    // State
    output logic [14:0] stepState
);
    typedef struct packed {
        logic [14:0] st;
    } dtu_step_t;

    dtu_step_t r_q;
    dtu_step_t r_d;

    always_comb begin
        r_d = r_q;
        if (startLoad) begin
            r_d.st = startValue;
        end else if (charStep) begin
            r_d.st[DTU_RS_COUNT_W-1:0] = r_q.st[DTU_RS_COUNT_W-1:0] + 12'h001;
            r_d.st[DTU_RS_CARRY_BIT] = carryIn;
            r_d.st[DTU_RS_PASS2_BIT] = r_q.st[DTU_RS_PASS2_BIT] | secondPass;
            r_d.st[DTU_RS_FAULT_BIT] = r_q.st[DTU_RS_FAULT_BIT] | digitFault;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            r_q <= '0;
        end else if (clkEn) begin
            r_q <= r_d;
        end
    end

    assign stepState = r_q.st;
endmodule // dtu_char_step

// *** verilog/dtu_trap_ctl.sv ***
/*
 * Decimal unit trap and interrupt stop controller with Avalon-MM registers.
 * Assumes main control supplies opcode decode, indexing, memory traffic and
 * the per-character strobes; one core clock, inputs synchronous to it.
 */
module dtu_trap_ctl
    import dtu_pkg::*;
(
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic clkEn,
    // Avalon-MM slave
    input wire logic [3:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic [3:0] avsByteEnable,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    // Main control handover
    input wire logic instrStart,
    input wire logic [5:0] instrOpcode,
    input wire logic [2:0] instrFunc,
    input wire logic monitorState,
    input wire logic interruptStop,
    input wire logic illegalWrite,
    // Character step feedback
    input wire logic charStep,
    input wire logic lastChar,
    input wire logic carryOut,
    input wire logic secondPass,
    input wire logic digitFault,
    input wire logic [1:0] fieldSign,
    // Results to main control
    output logic trapReq,
    output logic unitBusy,
    output logic controlReturn,
    output logic interrupted,
    output logic [1:0] conditionCode,
    output logic [14:0] thirdIndexOut
);
    import dtu_pkg::*;

    typedef struct packed {
        dtu_state_t state;
        logic [1:0] ctl;
        logic [14:0] restart;
        logic [14:0] recovery;
        logic stopSeen;
        logic resume;
        logic [5:0] op;
        logic [2:0] fn;
        logic [1:0] cond;
        logic trap;
        logic ret;
        logic intr;
        logic [31:0] rdata;
        logic wait_n;
        logic busy;
        logic waitReq;
    } dtu_regs_t;

    dtu_regs_t r_q;
    dtu_regs_t r_d;
    logic [14:0] stepState;
    logic stepLoad;
    logic [14:0] stepStart;
    logic isGroup;
    logic isRecovery;
    logic unitOn;
    logic restartFresh;
    logic busAccess;
    logic busAnswer;
    logic wrControl;
    logic wrRestartLo;
    logic wrRestartHi;
    logic [1:0] ctlWrite;
    logic [31:0] readWord;
    logic isAddSub;
    logic isSignTest;
    logic isStoreRec;
    logic trapAll;
    logic trapRecovery;
    logic nopRecovery;
    logic stepCarry;
    logic stepGate;

    assign isGroup = (instrOpcode >= DTU_OP_FIRST) && (instrOpcode <= DTU_OP_LAST);
    assign isRecovery = (instrOpcode == DTU_OP_70) &&
        ((instrFunc == DTU_FN_LOADREC) || (instrFunc == DTU_FN_STOREREC));
    assign unitOn = r_q.ctl[DTU_CTL_ENABLE_BIT] & r_q.ctl[DTU_CTL_FITTED_BIT];
    // Functions 66.0/66.1 never resume; 66.4/66.5 only after an illegal write
    assign restartFresh = (instrOpcode == DTU_OP_66) &&
        ((instrFunc == 3'h0) || (instrFunc == 3'h1) ||
         (illegalWrite && ((instrFunc == 3'h4) || (instrFunc == 3'h5))));
    assign stepLoad = (r_q.state == DTU_IDLE) && instrStart && isGroup && unitOn && !isRecovery;
    assign stepStart = (r_q.resume && !restartFresh) ? r_q.recovery : DTU_RS_RESET;
    assign busAccess = (avsRead || avsWrite) && !r_q.wait_n;
    // Writes commit on the answer edge only, so a request dropped early changes nothing
    assign busAnswer = avsWrite && r_q.wait_n;
    assign wrControl = busAnswer && avsByteEnable[0] && (avsAddress == DTU_OFS_CONTROL);
    assign wrRestartLo = busAnswer && avsByteEnable[0] && (avsAddress == DTU_OFS_RESTART);
    assign wrRestartHi = busAnswer && avsByteEnable[1] && (avsAddress == DTU_OFS_RESTART);
    assign ctlWrite = avsWriteData[1:0];
    assign isAddSub = (r_q.op == DTU_OP_67) && ((r_q.fn == DTU_FN_ADD) || (r_q.fn == DTU_FN_SUB));
    assign isSignTest = (r_q.op == DTU_OP_67) && (r_q.fn == DTU_FN_TEST);
    assign isStoreRec = isRecovery && (instrFunc == DTU_FN_STOREREC);
    assign trapAll = !unitOn && !isRecovery;
    assign trapRecovery = !unitOn && isRecovery && !monitorState;
    assign nopRecovery = !unitOn && isRecovery && monitorState;
    // Carry is internal restart state of add and subtract only, never an overflow flag
    assign stepCarry = carryOut && isAddSub;
    assign stepGate = charStep && (r_q.state == DTU_RUN);

    always_comb begin
        unique case (avsAddress)
            DTU_OFS_CONTROL: readWord = {30'h00000000, r_q.ctl};
            DTU_OFS_RESTART: readWord = {17'h00000, r_q.restart};
            DTU_OFS_STATUS: readWord = {26'h0000000, r_q.intr, r_q.resume, r_q.cond, r_q.state};
            DTU_OFS_RECOVERY: readWord = {17'h00000, r_q.recovery};
            default: readWord = DTU_UNMAPPED_DATA;
        endcase
    end

    dtu_char_step u_step (
        .core_clk(core_clk),
        .rstn(rstn),
        .clkEn(clkEn),
        .startLoad(stepLoad),
        .startValue(stepStart),
        .charStep(stepGate),
        .carryIn(stepCarry),
        .secondPass(secondPass),
        .digitFault(digitFault),
        .stepState(stepState)
    );

    always_comb begin
        r_d = r_q;
        r_d.trap = 1'b0;
        r_d.ret = 1'b0;
        r_d.wait_n = 1'b0;
        // Software writes go first so a hardware capture in the same cycle wins
        if (wrControl) begin
            r_d.ctl = ctlWrite;
        end
        if (wrRestartLo) begin
            r_d.restart[7:0] = avsWriteData[7:0];
        end
        if (wrRestartHi) begin
            r_d.restart[14:8] = avsWriteData[14:8];
        end
        unique case (r_q.state)
            DTU_IDLE: begin
                // Stop requests with no instruction running are dropped
                r_d.stopSeen = 1'b0;
                if (instrStart && isGroup) begin
                    if (trapAll || trapRecovery) begin
                        r_d.trap = 1'b1;
                    end else if (isRecovery) begin
                        if (nopRecovery) begin
                            r_d.ret = 1'b1;
                        end else begin
                            if (isStoreRec) begin
                                r_d.restart = r_q.recovery;
                            end else begin
                                r_d.recovery = r_q.restart;
                                r_d.resume = 1'b1;
                            end
                            r_d.ret = 1'b1;
                        end
                    end else begin
                        r_d.cond = 2'h0;
                        r_d.op = instrOpcode;
                        r_d.fn = instrFunc;
                        r_d.intr = 1'b0;
                        r_d.state = DTU_RUN;
                    end
                end
            end
            DTU_RUN: begin
                if (interruptStop) begin
                    r_d.stopSeen = 1'b1;
                end
                // Stop only on a character boundary, never mid-character
                if (charStep) begin
                    if (lastChar) begin
                        if (isSignTest) begin
                            r_d.cond = fieldSign;
                        end
                        r_d.resume = 1'b0;
                        r_d.state = DTU_DONE;
                    end else if (r_q.stopSeen || interruptStop) begin
                        r_d.intr = 1'b1;
                        r_d.state = DTU_DONE;
                    end
                end
            end
            DTU_DONE: begin
                if (r_q.intr) begin
                    r_d.restart = stepState;
                    r_d.recovery = stepState;
                    r_d.resume = 1'b1;
                end
                r_d.stopSeen = 1'b0;
                r_d.ret = 1'b1;
                r_d.state = DTU_IDLE;
            end
            default: begin
                r_d.state = DTU_IDLE;
            end
        endcase

        // Register port: one wait cycle, answered on the second edge
        if (busAccess) begin
            r_d.wait_n = 1'b1;
            if (avsRead) begin
                r_d.rdata = readWord;
            end
        end
        // Busy and waitrequest are registered so the outputs come straight from flops
        r_d.busy = (r_d.state != DTU_IDLE);
        r_d.waitReq = !r_d.wait_n;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            r_q <= '0;
            r_q.ctl <= DTU_CTL_RESET;
            r_q.state <= DTU_IDLE;
            r_q.waitReq <= 1'b1;
        end else if (clkEn) begin
            r_q <= r_d;
        end
    end

    assign avsReadData = r_q.rdata;
    assign avsWaitRequest = r_q.waitReq;
    assign trapReq = r_q.trap;
    assign unitBusy = r_q.busy;
    assign controlReturn = r_q.ret;
    assign interrupted = r_q.intr;
    assign conditionCode = r_q.cond;
    assign thirdIndexOut = r_q.restart;
endmodule // dtu_trap_ctl

// *** dv/dtu_props.sv ***
/* Port checker for dtu_trap_ctl.
   Assumes full byte enables on control writes. */
module dtu_props
    import dtu_pkg::*;
(
    // Bus and clock
    input wire logic core_clk, rstn, avsRead, avsWrite, avsWaitRequest,
    input wire logic [3:0] avsAddress,
    input wire logic [31:0] avsWriteData,
    // Handover
    input wire logic instrStart, monitorState, interruptStop, charStep, lastChar,
    input wire logic [5:0] instrOpcode,
    input wire logic [2:0] instrFunc,
    input wire logic [1:0] fieldSign, conditionCode,
    input wire logic trapReq, unitBusy, controlReturn, interrupted
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    logic [1:0] ctlQ;
    logic [8:0] opQ;
    wire logic go = instrStart && !unitBusy;
    wire logic rec = instrOpcode == DTU_OP_70 && instrFunc[2:1] == 2'h0;
    wire logic dec = instrOpcode >= DTU_OP_FIRST && instrOpcode <= DTU_OP_LAST;
    // Shadow of the control register, updated only at the answer edge
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctlQ <= DTU_CTL_RESET;
            opQ <= 9'h000;
        end else begin
            if (avsWrite && !avsWaitRequest && avsAddress == DTU_OFS_CONTROL) ctlQ <= avsWriteData[1:0];
            if (go) opQ <= {instrOpcode, instrFunc};
        end
    end
    property p_answer; (avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest; endproperty
    a_answer: assert property (p_answer) else $error("bus request not answered");
    property p_trapOff; go && dec && !rec && ctlQ != 2'h3 |=> trapReq && !unitBusy; endproperty
    a_trapOff: assert property (p_trapOff) else $error("decimal op not trapped");
    property p_recTrap; go && rec && !ctlQ[0] && !monitorState |=> trapReq; endproperty
    a_recTrap: assert property (p_recTrap) else $error("recovery op not trapped");
    property p_recNop; go && rec && !ctlQ[0] && monitorState |=> !trapReq && controlReturn && !unitBusy; endproperty
    a_recNop: assert property (p_recNop) else $error("recovery op not a no-op");
    property p_idle; !unitBusy && !instrStart |=> !unitBusy; endproperty
    a_idle: assert property (p_idle) else $error("unit left idle without start");
    property p_stop; unitBusy && interruptStop && charStep && !lastChar |-> ##2 controlReturn && interrupted; endproperty
    a_stop: assert property (p_stop) else $error("stop did not return control");
    property p_clear; go && dec && !rec && ctlQ == 2'h3 |=> unitBusy && conditionCode == 2'h0; endproperty
    a_clear: assert property (p_clear) else $error("condition not cleared");
    property p_sign;
        unitBusy && charStep && lastChar && opQ == {DTU_OP_67, DTU_FN_TEST} |-> ##2 conditionCode == $past(fieldSign, 2);
    endproperty
    a_sign: assert property (p_sign) else $error("sign test result wrong");
endmodule // dtu_props

bind dtu_trap_ctl dtu_props u_props (.core_clk, .rstn, .avsRead, .avsWrite, .avsWaitRequest, .avsAddress,
    .avsWriteData, .instrStart, .monitorState, .interruptStop, .charStep, .lastChar, .instrOpcode, .instrFunc,
    .fieldSign, .conditionCode, .trapReq, .unitBusy, .controlReturn, .interrupted);

// *** dv/dtu_main_model.sv ***
/* Main control model: hands instructions over and feeds character steps.
   Assumes one core clock shared with the unit. */
module dtu_main_model
    import dtu_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Handover and steps
    output logic instrStart, monitorState, interruptStop, illegalWrite,
    output logic [5:0] instrOpcode,
    output logic [2:0] instrFunc,
    output logic charStep, lastChar, carryOut, secondPass, digitFault,
    output logic [1:0] fieldSign,
    // Answers
    input wire logic trapReq, controlReturn
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {instrStart, monitorState, interruptStop, illegalWrite, instrOpcode, instrFunc, charStep, lastChar,
        carryOut, secondPass, digitFault, fieldSign} = '0;
    // Step flags are inverted between steps so stale values never look valid
    task automatic run(input logic [8:0] op, input int n, input int stopAt, input logic [2:0] flg,
        input logic [1:0] sgn, input logic ill, input logic mon, output logic trapped, output logic done);
        int k;
        @(posedge core_clk);
        {instrOpcode, instrFunc, monitorState, illegalWrite, instrStart} <= {op, mon, ill, 1'b1};
        @(posedge core_clk);
        instrStart <= 1'b0;
        @(negedge core_clk);
        trapped = trapReq;
        done = controlReturn;
        for (k = 1; k <= n && !trapped && !done; k++) begin
            @(posedge core_clk);
            {interruptStop, charStep, carryOut, secondPass, digitFault, fieldSign} <= {k == stopAt, 1'b0, ~flg, ~sgn};
            @(posedge core_clk);
            {charStep, lastChar, carryOut, secondPass, digitFault, fieldSign} <= {1'b1, k == n, flg, sgn};
            if (k == stopAt) break;
        end
        @(posedge core_clk);
        charStep <= 1'b0;
        for (k = 0; k < 8 && !done; k++) begin
            @(negedge core_clk);
            done = controlReturn;
        end
        @(posedge core_clk);
        interruptStop <= 1'b0;
    endtask
endmodule // dtu_main_model

// *** dv/decimal_unit_trap_interrupt_ctl_tb.sv ***
/* Self-checking bench for dtu_trap_ctl.
   Assumes the main control model and the bound checker. */
module decimal_unit_trap_interrupt_ctl_tb;
    import dtu_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 0, rstn = 0, avsRead = 0, avsWrite = 0, tr, dn;
    logic [3:0] avsAddress = 4'h0;
    logic [31:0] avsWriteData = 32'h0, avsReadData, rd;
    logic avsWaitRequest, instrStart, monitorState, interruptStop, illegalWrite, charStep, lastChar, carryOut;
    logic secondPass, digitFault, trapReq, unitBusy, controlReturn, interrupted;
    logic [5:0] instrOpcode;
    logic [2:0] instrFunc;
    logic [1:0] fieldSign, conditionCode;
    logic [14:0] thirdIndexOut;
    logic [8:0] fresh [4] = '{{DTU_OP_66, 3'h0}, {DTU_OP_66, 3'h1}, {DTU_OP_66, 3'h4}, {DTU_OP_66, 3'h5}};
    int miscompares = 0, nTests = 0;
    `define CHK(a, b) begin nTests++; if ((a) !== (b)) begin miscompares++; \
        $display("Error at %0t: got %0h expected %0h", $time, (a), (b)); end end
    initial forever #25 core_clk = ~core_clk;
    dtu_trap_ctl u_dut (.core_clk, .rstn, .clkEn(1'b1), .avsAddress, .avsRead, .avsWrite, .avsWriteData,
        .avsByteEnable(4'hF), .avsReadData, .avsWaitRequest, .instrStart, .instrOpcode, .instrFunc, .monitorState,
        .interruptStop, .illegalWrite, .charStep, .lastChar, .carryOut, .secondPass, .digitFault, .fieldSign,
        .trapReq, .unitBusy, .controlReturn, .interrupted, .conditionCode, .thirdIndexOut);
    dtu_main_model u_mc (.core_clk, .instrStart, .monitorState, .interruptStop, .illegalWrite, .instrOpcode,
        .instrFunc, .charStep, .lastChar, .carryOut, .secondPass, .digitFault, .fieldSign, .trapReq, .controlReturn);
    // Holds the request until the edge that samples waitrequest low
    task automatic access(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avsAddress <= a;
        avsWriteData <= d;
        {avsRead, avsWrite} <= {!wr, wr};
        do @(posedge core_clk); while (avsWaitRequest !== 1'b0);
        rd = avsReadData;
        {avsRead, avsWrite} <= 2'b00;
    endtask
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", nTests, miscompares);
        if (miscompares == 0 && nTests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge core_clk);
        miscompares++;
        end_sim();
    end
    initial begin
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        access(0, DTU_OFS_CONTROL, 0);
        `CHK(rd[1:0], DTU_CTL_RESET)
        access(0, 4'h6, 0);
        `CHK(rd, DTU_UNMAPPED_DATA)
        access(0, DTU_OFS_RESTART, 0);
        `CHK(rd[14:0], DTU_RS_RESET)
        u_mc.run({DTU_OP_67, DTU_FN_ADD}, 3, 0, 3'h0, 2'h0, 0, 0, tr, dn);
        `CHK({tr, dn, interrupted}, 3'b010)
        u_mc.run({DTU_OP_67, DTU_FN_TEST}, 2, 0, 3'h0, 2'h2, 0, 0, tr, dn);
        `CHK(conditionCode, 2'h2)
        access(0, DTU_OFS_STATUS, 0);
        `CHK(rd[5:0], 6'h08)
        u_mc.run({DTU_OP_67, DTU_FN_ADD}, 6, 3, 3'h7, 2'h0, 0, 0, tr, dn);
        `CHK({dn, interrupted, thirdIndexOut}, {2'b11, 15'h7003})
        access(0, DTU_OFS_RESTART, 0);
        `CHK(rd[14:0], 15'h7003)
        access(1, DTU_OFS_RESTART, 0);
        u_mc.run({DTU_OP_70, DTU_FN_STOREREC}, 0, 0, 3'h0, 2'h0, 0, 0, tr, dn);
        access(0, DTU_OFS_RESTART, 0);
        `CHK({tr, dn, rd[14:0]}, {2'b01, 15'h7003})
        access(1, DTU_OFS_RESTART, 32'h5);
        u_mc.run({DTU_OP_70, DTU_FN_LOADREC}, 0, 0, 3'h0, 2'h0, 0, 0, tr, dn);
        access(0, DTU_OFS_RECOVERY, 0);
        `CHK(rd[14:0], 15'h0005)
        u_mc.run({DTU_OP_67, DTU_FN_ADD}, 3, 1, 3'h0, 2'h0, 0, 0, tr, dn);
        `CHK(thirdIndexOut, 15'h0006)
        for (int i = 0; i < 4; i++) begin
            access(1, DTU_OFS_RESTART, 32'h5);
            u_mc.run({DTU_OP_70, DTU_FN_LOADREC}, 0, 0, 3'h0, 2'h0, 0, 0, tr, dn);
            u_mc.run(fresh[i], 3, 1, 3'h0, 2'h0, i >= 2, 0, tr, dn);
            `CHK(thirdIndexOut[11:0], 12'h001)
        end
        access(1, DTU_OFS_CONTROL, 0);
        for (logic [5:0] op = DTU_OP_FIRST; op <= DTU_OP_LAST; op++) begin
            u_mc.run({op, 3'h2}, 2, 0, 3'h0, 2'h0, 0, 0, tr, dn);
            `CHK(tr, 1'b1)
        end
        u_mc.run({DTU_OP_70, DTU_FN_LOADREC}, 0, 0, 3'h0, 2'h0, 0, 0, tr, dn);
        `CHK(tr, 1'b1)
        u_mc.run({DTU_OP_70, DTU_FN_STOREREC}, 0, 0, 3'h0, 2'h0, 0, 1, tr, dn);
        `CHK({tr, dn}, 2'b01)
        access(1, DTU_OFS_CONTROL, 32'h1);
        u_mc.run({DTU_OP_67, DTU_FN_ADD}, 2, 0, 3'h0, 2'h0, 0, 0, tr, dn);
        `CHK(tr, 1'b1)
        end_sim();
    end
endmodule // decimal_unit_trap_interrupt_ctl_tb
